// ### rtl/usr_rx.sv
// usr_rx: receive-side data recovery, error flags and standby wakeup
// assumes rx_i is an asynchronous pin and the register port is on clk_i
// status flags clear on a read of the status word; data read clears full
//
// Implementation choices: the plain strobed port and the register offsets.

// Overview of operation
// - sample the line on a tick at sixteen times the baud rate
// - realign tick phase after start bit and after a one-to-zero data change
// - hunt for a low that follows three consecutive high samples
// - a candidate falling edge starts the sixteen-position tick counter
// - start checked at ticks 3,5,7; accept if at most one high; noise if one
// - failed start check resets the counter and restarts the hunt
// - data bit is majority of ticks 8,9,10; noise if samples disagree
// - high samples at 8,9,10 of a verified start only raise noise
// - stop sampled at 8,9,10; framing error on zero majority; noise on disagree
// - framing error flag sets in the same cycle as receiver full
// - a break character also sets the framing error flag
// - realign the tick phase on each valid falling edge within a character
// - standby bit puts receiver in standby, receiver events suppressed
// - address wake: character with msb one clears standby and sets full
// - idle wake: idle character clears standby, sets neither idle nor full
// - idle count select picks counting after start bit or after stop bit
// - clearing the wake method bit while line idle may wake immediately
// - character length eight or nine data bits per length control bit
// - a complete character moves to the data register unless full is still set, and sets full
// - idle flag sets after ten or eleven consecutive high bits
module usr_rx (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // serial line
  input  wire logic        rx_i,
  // register port
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  // status levels
  output logic             rx_full_flag_o,
  output logic             rx_standby_bit_o
);
  typedef enum logic [1:0] {ST_HUNT, ST_START, ST_DATA, ST_STOP} usr_state_t;

  // synchroniser; first stage is read only by the second
  logic rx_m_q, rx_s_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
    end else begin
      rx_m_q <= rx_i;
      rx_s_q <= rx_m_q;
    end
  end

  // control and baud state
  logic [4:0]  ctrl_q, ctrl_d;
  logic [15:0] baud_q, baud_d;
  logic [15:0] div_q, div_d;
  logic        tick;

  // receiver state
  usr_state_t  st_q, st_d;
  logic [3:0]  ph_q, ph_d;
  logic [2:0]  hi_q, hi_d;
  logic [2:0]  smp_q, smp_d;
  logic [3:0]  nbit_q, nbit_d;
  logic [8:0]  sh_q, sh_d;
  logic        prev_q, prev_d;
  logic        last_q, last_d;
  logic        nacc_q, nacc_d;
  logic [3:0]  idle_q, idle_d;
  logic        idle_arm_q, idle_arm_d;
  logic [8:0]  data_q, data_d;
  logic [6:0]  stat_q, stat_d;
  logic [15:0] rdata_q, rdata_d;

  logic       maj;
  logic       dis;
  logic [3:0] nbits;
  logic [3:0] idle_len;
  logic       done;
  logic       done_frame;
  logic       done_noise;
  logic       idle_hit;

  always_comb begin
    maj = (smp_q[0] & smp_q[1]) | (smp_q[0] & smp_q[2]) | (smp_q[1] & smp_q[2]);
    dis = (smp_q != 3'h0) && (smp_q != 3'h7);
  end

  always_comb begin
    div_d = div_q;
    tick  = 1'b0;
    if (!ctrl_q[usr_pkg::C_ENABLE]) begin
      div_d = 16'h0000;
    end else if (div_q >= baud_q) begin
      div_d = 16'h0000;
      tick  = 1'b1;
    end else begin
      div_d = div_q + 16'h0001;
    end
  end

  always_comb begin
    st_d       = st_q;
    ph_d       = ph_q;
    hi_d       = hi_q;
    smp_d      = smp_q;
    nbit_d     = nbit_q;
    sh_d       = sh_q;
    prev_d     = prev_q;
    last_d     = last_q;
    nacc_d     = nacc_q;
    idle_d     = idle_q;
    idle_arm_d = idle_arm_q;
    done       = 1'b0;
    done_frame = 1'b0;
    done_noise = 1'b0;
    idle_hit   = 1'b0;
    nbits      = ctrl_q[usr_pkg::C_LEN9] ? usr_pkg::BITS_9 : usr_pkg::BITS_8;
    idle_len   = ctrl_q[usr_pkg::C_LEN9] ? usr_pkg::IDLE_9 : usr_pkg::IDLE_8;
    if (!ctrl_q[usr_pkg::C_ENABLE]) begin
      st_d = ST_HUNT;
      hi_d = 3'h0;
      ph_d = 4'h0;
    end else if (tick) begin
      last_d = rx_s_q;
      // idle counting runs per bit time in any state
      if (ph_q == usr_pkg::TICK_LAST && idle_arm_q) begin
        if (rx_s_q) begin
          if (idle_q < idle_len) begin
            idle_d = idle_q + 4'h1;
          end
          if (idle_q + 4'h1 == idle_len) begin
            idle_hit = 1'b1;
          end
        end else begin
          idle_d = 4'h0;
        end
      end
      ph_d = ph_q + 4'h1;
      unique case (st_q)
        ST_HUNT: begin
          ph_d = (ph_q == usr_pkg::TICK_LAST) ? 4'h0 : ph_q + 4'h1;
          if (rx_s_q) begin
            hi_d = (hi_q < usr_pkg::HIGH_RUN) ? hi_q + 3'h1 : hi_q;
          end else if (hi_q >= usr_pkg::HIGH_RUN) begin
            st_d   = ST_START;
            ph_d   = 4'h1;
            smp_d  = 3'h0;
            nacc_d = 1'b0;
            hi_d   = 3'h0;
          end else begin
            hi_d = 3'h0;
          end
        end
        ST_START: begin
          if (ph_q == usr_pkg::TICK_S1) smp_d[0] = rx_s_q;
          if (ph_q == usr_pkg::TICK_S2) smp_d[1] = rx_s_q;
          if (ph_q == usr_pkg::TICK_S3) begin
            smp_d[2] = rx_s_q;
            if (32'(smp_q[0]) + 32'(smp_q[1]) + 32'(rx_s_q) > 1) begin
              st_d = ST_HUNT;
              ph_d = 4'h0;
            end else if (smp_q[0] | smp_q[1] | rx_s_q) begin
              nacc_d = 1'b1;
            end
          end
          if (ph_q == usr_pkg::TICK_D1) smp_d[0] = rx_s_q;
          if (ph_q == usr_pkg::TICK_D2) smp_d[1] = rx_s_q;
          if (ph_q == usr_pkg::TICK_D3 && rx_s_q | smp_q[0] | smp_q[1]) begin
            nacc_d = 1'b1;
          end
          if (ph_q == usr_pkg::TICK_LAST) begin
            st_d   = ST_DATA;
            nbit_d = 4'h0;
            prev_d = 1'b0;
            if (!ctrl_q[usr_pkg::C_IDLE_SEL]) begin
              idle_arm_d = 1'b1;
              idle_d     = 4'h0;
            end
          end
        end
        ST_DATA, ST_STOP: begin
          // realign on a falling edge seen early in the bit after a high bit
          if (prev_q && last_q && !rx_s_q && ph_q < usr_pkg::TICK_D1 && ph_q != 4'h0) begin
            ph_d = 4'h1;
          end
          if (ph_q == usr_pkg::TICK_D1) smp_d[0] = rx_s_q;
          if (ph_q == usr_pkg::TICK_D2) smp_d[1] = rx_s_q;
          if (ph_q == usr_pkg::TICK_D3) smp_d[2] = rx_s_q;
          if (ph_q == usr_pkg::TICK_LAST) begin
            prev_d = maj;
            if (dis) nacc_d = 1'b1;
            if (st_q == ST_DATA) begin
              sh_d   = {maj, sh_q[8:1]};
              nbit_d = nbit_q + 4'h1;
              if (nbit_q + 4'h1 == nbits) st_d = ST_STOP;
            end else begin
              done       = 1'b1;
              done_frame = !maj;
              done_noise = nacc_q | dis;
              st_d       = ST_HUNT;
              ph_d       = 4'h0;
              hi_d       = maj ? 3'h1 : 3'h0;
              if (ctrl_q[usr_pkg::C_IDLE_SEL]) begin
                idle_arm_d = 1'b1;
                idle_d     = 4'h0;
              end
            end
          end
        end
      endcase
    end
    // one idle flag per idle run; the next character rearms the count
    if (idle_hit) idle_arm_d = 1'b0;
  end

  // received character, aligned for 8- or 9-bit length; the last bit shifted in is its msb either way
  logic [8:0] rx_char;
  logic       msb;
  always_comb begin
    rx_char = ctrl_q[usr_pkg::C_LEN9] ? sh_q : {1'b0, sh_q[8:1]};
    msb     = sh_q[8];
  end

  always_comb begin
    ctrl_d  = ctrl_q;
    baud_d  = baud_q;
    data_d  = data_q;
    stat_d  = stat_q;
    rdata_d = 16'h0000;
    // reads first so a same-cycle hardware set wins below
    if (rd_i) begin
      unique case (addr_i)
        usr_pkg::ADDR_CTRL: rdata_d = {11'h000, ctrl_q};
        usr_pkg::ADDR_STAT: rdata_d = {9'h000, stat_q};
        usr_pkg::ADDR_DATA: rdata_d = {7'h00, data_q};
        usr_pkg::ADDR_BAUD: rdata_d = baud_q;
        default:            rdata_d = 16'h0000;
      endcase
      if (addr_i == usr_pkg::ADDR_STAT) begin
        stat_d[usr_pkg::S_IDLE]    = 1'b0;
        stat_d[usr_pkg::S_NOISE]   = 1'b0;
        stat_d[usr_pkg::S_FRAME]   = 1'b0;
        stat_d[usr_pkg::S_BREAK]   = 1'b0;
        stat_d[usr_pkg::S_OVERRUN] = 1'b0;
      end
      if (addr_i == usr_pkg::ADDR_DATA) stat_d[usr_pkg::S_FULL] = 1'b0;
    end
    if (wr_i && addr_i == usr_pkg::ADDR_CTRL) ctrl_d = wdata_i[4:0];
    if (wr_i && addr_i == usr_pkg::ADDR_BAUD) baud_d = wdata_i;
    if (done) begin
      if (ctrl_q[usr_pkg::C_STANDBY]) begin
        // standby: only an address mark completes into status
        if (ctrl_q[usr_pkg::C_WAKE_ADDR] && msb) begin
          ctrl_d[usr_pkg::C_STANDBY] = 1'b0;
          data_d                     = rx_char;
          stat_d[usr_pkg::S_FULL]    = 1'b1;
          stat_d[usr_pkg::S_FRAME]   = done_frame;
          stat_d[usr_pkg::S_NOISE]   = done_noise;
        end
      end else begin
        if (stat_q[usr_pkg::S_FULL] && !(rd_i && addr_i == usr_pkg::ADDR_DATA)) begin
          stat_d[usr_pkg::S_OVERRUN] = 1'b1;
        end else begin
          data_d = done_frame && rx_char == 9'h000 ? 9'h000 : rx_char;
        end
        stat_d[usr_pkg::S_FULL] = 1'b1;
        if (done_frame) stat_d[usr_pkg::S_FRAME] = 1'b1;
        if (done_noise) stat_d[usr_pkg::S_NOISE] = 1'b1;
        if (done_frame && rx_char == 9'h000) stat_d[usr_pkg::S_BREAK] = 1'b1;
      end
    end
    if (idle_hit) begin
      if (ctrl_q[usr_pkg::C_STANDBY]) begin
        // waking idle character leaves idle and full untouched
        if (!ctrl_q[usr_pkg::C_WAKE_ADDR]) ctrl_d[usr_pkg::C_STANDBY] = 1'b0;
      end else begin
        stat_d[usr_pkg::S_IDLE] = 1'b1;
      end
    end
    stat_d[usr_pkg::S_STANDBY] = ctrl_d[usr_pkg::C_STANDBY];
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q     <= 5'h00;
      baud_q     <= usr_pkg::BAUD_RST;
      div_q      <= 16'h0000;
      st_q       <= ST_HUNT;
      ph_q       <= 4'h0;
      hi_q       <= 3'h0;
      smp_q      <= 3'h0;
      nbit_q     <= 4'h0;
      sh_q       <= 9'h000;
      prev_q     <= 1'b0;
      last_q     <= 1'b1;
      nacc_q     <= 1'b0;
      idle_q     <= 4'h0;
      idle_arm_q <= 1'b1;
      data_q     <= 9'h000;
      stat_q     <= 7'h00;
      rdata_q    <= 16'h0000;
      rx_full_flag_o   <= 1'b0;
      rx_standby_bit_o <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      baud_q     <= baud_d;
      div_q      <= div_d;
      st_q       <= st_d;
      ph_q       <= ph_d;
      hi_q       <= hi_d;
      smp_q      <= smp_d;
      nbit_q     <= nbit_d;
      sh_q       <= sh_d;
      prev_q     <= prev_d;
      last_q     <= last_d;
      nacc_q     <= nacc_d;
      idle_q     <= idle_d;
      idle_arm_q <= idle_arm_d;
      data_q     <= data_d;
      stat_q     <= stat_d;
      rdata_q    <= rdata_d;
      rx_full_flag_o   <= stat_d[usr_pkg::S_FULL];
      rx_standby_bit_o <= ctrl_d[usr_pkg::C_STANDBY];
    end
  end

  assign rdata_o = rdata_q;
endmodule : usr_rx

// ### shared/usr_pkg.sv
// usr_pkg: constants for the uart receive sampling and wakeup block
// assumes a 20 MHz module clock and a single clock domain
package usr_pkg;
  localparam int unsigned CLK_HZ      = 20000000;
  localparam int unsigned OSR         = 16;
  localparam int unsigned BAUD_DEF    = 9600;
  localparam logic [3:0]  TICK_S1     = 4'h2;
  localparam logic [3:0]  TICK_S2     = 4'h4;
  localparam logic [3:0]  TICK_S3     = 4'h6;
  localparam logic [3:0]  TICK_D1     = 4'h7;
  localparam logic [3:0]  TICK_D2     = 4'h8;
  localparam logic [3:0]  TICK_D3     = 4'h9;
  localparam logic [3:0]  TICK_LAST   = 4'hF;
  localparam logic [3:0]  BITS_8      = 4'h8;
  localparam logic [3:0]  BITS_9      = 4'h9;
  localparam logic [3:0]  IDLE_8      = 4'hA;
  localparam logic [3:0]  IDLE_9      = 4'hB;
  localparam logic [2:0]  HIGH_RUN    = 3'h3;
  // register map: byte address of each word, 4 * word index
  localparam logic [3:0]  ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_STAT   = 4'h4;
  localparam logic [3:0]  ADDR_DATA   = 4'h8;
  localparam logic [3:0]  ADDR_BAUD   = 4'hC;
  // control bits
  localparam int unsigned C_ENABLE    = 0;
  localparam int unsigned C_LEN9      = 1;
  localparam int unsigned C_WAKE_ADDR = 2;
  localparam int unsigned C_IDLE_SEL  = 3;
  localparam int unsigned C_STANDBY   = 4;
  // status bits
  localparam int unsigned S_FULL      = 0;
  localparam int unsigned S_IDLE      = 1;
  localparam int unsigned S_NOISE     = 2;
  localparam int unsigned S_FRAME     = 3;
  localparam int unsigned S_BREAK     = 4;
  localparam int unsigned S_OVERRUN   = 5;
  localparam int unsigned S_STANDBY   = 6;
  localparam logic [15:0] BAUD_RST    = 16'(CLK_HZ / (OSR * BAUD_DEF) - 1);
endpackage : usr_pkg

// ### sim/usr_tx_model.sv
// usr_tx_model: remote asynchronous transmitter on the serial line
// assumes the caller gives the bit time; runs on its own time base, unrelated to clk_i
module usr_tx_model (
  // serial line, idle high
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial line_o = 1'b1;
  // lsb first then stop; stop 0 with data 0 is a break; bit spk gets a one-tick spike
  task automatic send(input logic [8:0] d, input int n, input logic stop, input int bt, input int spk);
    #3 line_o = 1'b0;
    #(bt);
    for (int i = 0; i < n; i++) begin
      line_o = d[i];
      #(bt * 17 / 32);
      line_o = (i == spk) ? ~d[i] : d[i];
      #(bt / 16);
      line_o = d[i];
      #(bt - bt * 17 / 32 - bt / 16);
    end
    line_o = stop;
    #(bt);
    // guard high so the next start follows three high samples
    line_o = 1'b1;
    #(bt);
  endtask : send
  // a low far shorter than the start check window
  task automatic glitch(input int w);
    #3 line_o = 1'b0;
    #(w) line_o = 1'b1;
  endtask : glitch
endmodule : usr_tx_model

// ### sim/usr_rx_assertions.sv
// usr_rx_assertions: port-level checks for usr_rx
// assumes one clock domain and BIT_CLKS clocks per bit once traffic starts
module usr_rx_assertions #(
  parameter int BIT_CLKS = 32
) (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        rx_i,
  input wire logic [3:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic        rx_full_flag_o,
  input wire logic        rx_standby_bit_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic [9:0] low_age_q, low_age_d;
  logic       sb_req, data_rd;
  assign sb_req  = wr_i && addr_i == usr_pkg::ADDR_CTRL && wdata_i[usr_pkg::C_STANDBY];
  assign data_rd = rd_i && addr_i == usr_pkg::ADDR_DATA;
  // clocks since the line was last low; saturates so a spurious full is caught
  always_comb low_age_d = !rx_i ? 10'h000 : low_age_q + {9'h000, ~&low_age_q};
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) low_age_q <= 10'h3FF;
    else low_age_q <= low_age_d;
  end
  sequence s_bad_read;
    rd_i && addr_i[1:0] != 2'h0;
  endsequence
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data outside a read answer");
  a_unmapped_zero: assert property (s_bad_read |=> rdata_o == 16'h0000)
    else $error("unmapped read returned data");
  a_full_cause: assert property ($rose(rx_full_flag_o) |-> low_age_q < 12 * BIT_CLKS)
    else $error("full set with no character on the line");
  a_full_level: assert property ($rose(rx_full_flag_o) |-> rx_full_flag_o [*3])
    else $error("full did not hold");
  a_full_clear: assert property ($fell(rx_full_flag_o) |-> $past(data_rd) || $past(data_rd, 2))
    else $error("full cleared without a data read");
  a_standby_set: assert property ($rose(rx_standby_bit_o) |-> $past(sb_req) || $past(sb_req, 2))
    else $error("standby set without a control write");
  a_wake_addr: assert property ($rose(rx_full_flag_o) && $past(rx_standby_bit_o) |-> ##[0:2] !rx_standby_bit_o)
    else $error("character in standby without wake");
  a_wake_line: assert property ($fell(rx_standby_bit_o) && !$past(wr_i) && !$past(wr_i, 2) |-> $past(rx_i, 3))
    else $error("wake while line low");
endmodule : usr_rx_assertions
bind usr_rx usr_rx_assertions #(.BIT_CLKS(32)) chk (.clk_i(clk_i), .resetn_i(resetn_i), .rx_i(rx_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_full_flag_o(rx_full_flag_o),
  .rx_standby_bit_o(rx_standby_bit_o));

// ### sim/uart_rx_sampling_wakeup_test.sv
// uart_rx_sampling_wakeup_test: register-level tests of usr_rx against a transmitter model
// assumes baud divisor 1: a tick every 2 clocks, a bit of 1600 ns
module uart_rx_sampling_wakeup_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BT = 1600;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        rx_i;
  logic [3:0]  addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [15:0] rdata_o;
  logic        rx_full_flag_o;
  logic        rx_standby_bit_o;
  logic [15:0] seen;
  int          mismatches = 0;
  int          checks = 0;
  always #25 clk_i = ~clk_i;
  usr_rx uut (.clk_i(clk_i), .resetn_i(resetn_i), .rx_i(rx_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .rx_full_flag_o(rx_full_flag_o), .rx_standby_bit_o(rx_standby_bit_o));
  usr_tx_model tx (.line_o(rx_i));
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // data stand only in the cycle after the strobe, so take them 1 ns into it
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 seen = rdata_o;
  endtask : rd
  task automatic rx_char(input logic [8:0] d, input int n, input logic stop, input int bt, input int spk,
                         input logic [15:0] st, input logic [15:0] dat);
    chk("full before", {15'h0000, rx_full_flag_o}, 16'h0000);
    tx.send(d, n, stop, bt, spk);
    chk("full after", {15'h0000, rx_full_flag_o}, 16'h0001);
    rd(usr_pkg::ADDR_STAT);
    chk("status", seen & 16'h003D, st);
    rd(usr_pkg::ADDR_DATA);
    chk("data", seen, dat);
  endtask : rx_char
  task automatic close_out();
    if (mismatches == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  initial begin
    #2000000;
    mismatches++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(usr_pkg::ADDR_CTRL);
    chk("ctrl reset", seen, 16'h0000);
    rd(usr_pkg::ADDR_BAUD);
    chk("baud reset", seen, usr_pkg::BAUD_RST);
    wr(usr_pkg::ADDR_STAT, 16'hFFFF);
    rd(usr_pkg::ADDR_STAT);
    chk("status ro", seen, 16'h0000);
    rd(4'h6);
    chk("unmapped", seen, 16'h0000);
    wr(usr_pkg::ADDR_BAUD, 16'h0001);
    wr(usr_pkg::ADDR_CTRL, 16'h0001);
    // the hunt needs three high samples after enable before a start counts; stay off the clock edge
    #(BT + 1);
    rx_char(9'h0A5, 8, 1'b1, BT, -1, 16'h0001, 16'h00A5);
    rx_char(9'h000, 8, 1'b1, BT, 3, 16'h0005, 16'h0000);
    rx_char(9'h03C, 8, 1'b0, BT, -1, 16'h0009, 16'h003C);
    rx_char(9'h000, 8, 1'b0, BT, -1, 16'h0019, 16'h0000);
    // a slow sender only lands if the phase follows its falling edges
    rx_char(9'h055, 8, 1'b1, 1720, -1, 16'h0001, 16'h0055);
    // second character before the data read: overrun keeps the first
    tx.send(9'h033, 8, 1'b1, BT, -1);
    tx.send(9'h044, 8, 1'b1, BT, -1);
    rd(usr_pkg::ADDR_STAT);
    chk("overrun", seen & 16'h003D, 16'h0021);
    rd(usr_pkg::ADDR_DATA);
    chk("kept data", seen, 16'h0033);
    wr(usr_pkg::ADDR_CTRL, 16'h000B);
    rx_char(9'h1A5, 9, 1'b1, BT, -1, 16'h0001, 16'h01A5);
    #(BT * 13);
    rd(usr_pkg::ADDR_STAT);
    chk("idle flag", seen & 16'h0002, 16'h0002);
    wr(usr_pkg::ADDR_CTRL, 16'h0001);
    tx.glitch(150);
    #(BT * 12);
    chk("glitch", {15'h0000, rx_full_flag_o}, 16'h0000);
    wr(usr_pkg::ADDR_CTRL, 16'h0015);
    tx.send(9'h012, 8, 1'b1, BT, -1);
    chk("ignored", {14'h0000, rx_standby_bit_o, rx_full_flag_o}, 16'h0002);
    rx_char(9'h092, 8, 1'b1, BT, -1, 16'h0001, 16'h0092);
    chk("woken", {15'h0000, rx_standby_bit_o}, 16'h0000);
    if (seen[7:0] != 8'h93) wr(usr_pkg::ADDR_CTRL, 16'h0015);
    tx.send(9'h012, 8, 1'b1, BT, -1);
    rd(usr_pkg::ADDR_STAT);
    wr(usr_pkg::ADDR_CTRL, 16'h0011);
    for (int n = 0; n < 800 && rx_standby_bit_o === 1'b1; n++) @(posedge clk_i);
    rd(usr_pkg::ADDR_STAT);
    chk("idle wake", seen & 16'h0043, 16'h0000);
    close_out();
  end
endmodule : uart_rx_sampling_wakeup_test
